// ### tmccs_pkg.sv
package tmccs_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_RUN = 8'h08;
  localparam logic [7:0] OFF_CMP1 = 8'h0c;
  localparam logic [7:0] OFF_CAP0 = 8'h10;
  localparam logic [7:0] OFF_CAP1 = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_SOFT_CAP_BIT = 6;
  localparam int CTRL_OVERRIDE_BIT = 4;
  localparam int RUN_COUNT_BIT = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [6:0] MODE_RESET = 7'h00;
  localparam logic [15:0] CMP1_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] PRESC_RESET = 8'h00;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TMCCS_CAP_OFF = 2'b00,
    TMCCS_CAP_PINS = 2'b01,
    TMCCS_CAP_PIN0 = 2'b10,
    TMCCS_CAP_PARTNER = 2'b11
  } tmccs_cap_sel_t;

  typedef enum logic [2:0] {
    TMCCS_CLK_PIN0 = 3'b000,
    TMCCS_CLK_DIV1 = 3'b001,
    TMCCS_CLK_DIV4 = 3'b010,
    TMCCS_CLK_DIV16 = 3'b011,
    TMCCS_CLK_DIV32 = 3'b100,
    TMCCS_CLK_DIV64 = 3'b101,
    TMCCS_CLK_DIV128 = 3'b110,
    TMCCS_CLK_DIV256 = 3'b111
  } tmccs_clk_sel_t;

  typedef struct packed {
    logic spare7;
    tmccs_cap_sel_t capture_timing_sel;
    logic match1_clear_enable;
    tmccs_clk_sel_t clk_sel;
  } tmccs_mode_t;

endpackage : tmccs_pkg

// ### tmccs_sync_edge.sv
`timescale 1ns/10ps
module tmccs_sync_edge (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic meta_next;
  logic sync_next;
  logic prev_next;

  // ------------------------------------------------------------
  // two-flop synchroniser, edge taken on the second stage
  // ------------------------------------------------------------
  always_comb begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    prev_next = prev_reg;
    if (clk_en) begin
      meta_next = async_in;
      sync_next = meta_reg;
      prev_next = sync_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule : tmccs_sync_edge

// ### tmccs_capture_reg.sv
`timescale 1ns/10ps
module tmccs_capture_reg #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic [WIDTH-1:0] held
);
  logic [WIDTH-1:0] held_reg;
  logic [WIDTH-1:0] held_next;

  always_comb begin
    held_next = held_reg;
    if (clk_en && load) begin
      held_next = value;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      held_reg <= '0;
    end else begin
      held_reg <= held_next;
    end
  end

  assign held = held_reg;
endmodule : tmccs_capture_reg

// ### tmccs_timer_mode.sv
// Function
// - writing 0 to soft capture bit copies counter to capture 0; reads one
// - capture timing 00 lets no hardware event load capture registers
// - timing 01: pin0 rise loads capture 0, pin1 rise loads capture 1
// - timing 10: pin0 rise loads capture 0, pin0 fall loads capture 1
// - timing 11: partner match rise loads capture 0, fall loads capture 1
// - partner is channel 7 for 0-1, 8 for 2-3, 9 for 4-6
// - clear enable set clears counter on match with compare 1
// - base clock override forces base clock regardless of clock select
// - without override, clock select 000 counts pin0 rising edges
// - without override, codes 001-111 pick divide 1,4,16,32,64,128,256
// - override one selects base clock, zero defers to clock select
// - run bit zero stops and clears counter, one lets it count
`timescale 1ns/10ps
module tmccs_timer_mode #(
  parameter int CHANNEL = 0,
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_input_pin0,
  input wire logic timer_input_pin1,
  input wire logic base_clock_tick,
  input wire logic channel7_match_out,
  input wire logic channel8_match_out,
  input wire logic channel9_match_out,
  output logic match1_pulse,
  output logic [COUNT_W-1:0] timer_count
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tmccs_pkg::tmccs_mode_t mode_reg;
  tmccs_pkg::tmccs_mode_t mode_next;
  logic base_clock_override_reg;
  logic base_clock_override_next;
  logic count_run_bit_reg;
  logic count_run_bit_next;
  logic [COUNT_W-1:0] compare_reg1_reg;
  logic [COUNT_W-1:0] compare_reg1_next;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic [7:0] presc_reg;
  logic [7:0] presc_next;
  logic match1_reg;
  logic match1_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;

  logic [COUNT_W-1:0] capture_reg0;
  logic [COUNT_W-1:0] capture_reg1;
  logic pin0_rise;
  logic pin0_fall;
  logic pin1_rise;
  logic partner_rise;
  logic partner_fall;
  logic partner_match_output;
  logic bus_take;
  logic bus_wr;
  logic soft_capture_strobe;
  logic count_tick;
  logic match_hit;
  logic load0;
  logic load1;

  // ------------------------------------------------------------
  // partner match source
  // ------------------------------------------------------------
  localparam bit PARTNER_OK = (CHANNEL <= 6);

  always_comb begin
    if (CHANNEL <= 1) begin
      partner_match_output = channel7_match_out;
    end else if (CHANNEL <= 3) begin
      partner_match_output = channel8_match_out;
    end else if (CHANNEL <= 6) begin
      partner_match_output = channel9_match_out;
    end else begin
      partner_match_output = 1'b0;
    end
  end

  tmccs_sync_edge u_pin0 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(timer_input_pin0),
    .rise(pin0_rise),
    .fall(pin0_fall)
  );

  tmccs_sync_edge u_pin1 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(timer_input_pin1),
    .rise(pin1_rise),
    .fall()
  );

  tmccs_sync_edge u_partner (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(partner_match_output),
    .rise(partner_rise),
    .fall(partner_fall)
  );

  // ------------------------------------------------------------
  // wishbone slave: registered ack, write lands at the edge that samples ack
  // ------------------------------------------------------------
  assign bus_take = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign soft_capture_strobe = bus_wr && (wb_adr_i == tmccs_pkg::OFF_MODE) && wb_sel_i[0]
    && !wb_dat_i[tmccs_pkg::MODE_SOFT_CAP_BIT];

  always_comb begin
    ack_next = ack_reg;
    rdat_next = rdat_reg;
    mode_next = mode_reg;
    base_clock_override_next = base_clock_override_reg;
    count_run_bit_next = count_run_bit_reg;
    compare_reg1_next = compare_reg1_reg;
    if (clk_en) begin
      ack_next = bus_take;
      rdat_next = 32'h0000_0000;
      if (bus_take && !wb_we_i) begin
        unique case (wb_adr_i)
          tmccs_pkg::OFF_MODE: rdat_next = {24'h00_0000, mode_reg.spare7, 1'b1, mode_reg[5:0]};
          tmccs_pkg::OFF_CTRL: rdat_next[tmccs_pkg::CTRL_OVERRIDE_BIT] = base_clock_override_reg;
          tmccs_pkg::OFF_RUN: rdat_next[tmccs_pkg::RUN_COUNT_BIT] = count_run_bit_reg;
          tmccs_pkg::OFF_CMP1: rdat_next[COUNT_W-1:0] = compare_reg1_reg;
          tmccs_pkg::OFF_CAP0: rdat_next[COUNT_W-1:0] = capture_reg0;
          tmccs_pkg::OFF_CAP1: rdat_next[COUNT_W-1:0] = capture_reg1;
          tmccs_pkg::OFF_COUNT: rdat_next[COUNT_W-1:0] = count_reg;
          default: rdat_next = 32'h0000_0000;
        endcase
      end
      if (bus_wr) begin
        unique case (wb_adr_i)
          tmccs_pkg::OFF_MODE: begin
            if (wb_sel_i[0]) begin
              mode_next = {wb_dat_i[7], wb_dat_i[5:0]};
            end
          end
          tmccs_pkg::OFF_CTRL: begin
            if (wb_sel_i[0]) begin
              base_clock_override_next = wb_dat_i[tmccs_pkg::CTRL_OVERRIDE_BIT];
            end
          end
          tmccs_pkg::OFF_RUN: begin
            if (wb_sel_i[0]) begin
              count_run_bit_next = wb_dat_i[tmccs_pkg::RUN_COUNT_BIT];
            end
          end
          tmccs_pkg::OFF_CMP1: begin
            if (wb_sel_i[0]) begin
              compare_reg1_next[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              compare_reg1_next[15:8] = wb_dat_i[15:8];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      mode_reg <= tmccs_pkg::MODE_RESET;
      base_clock_override_reg <= 1'b0;
      count_run_bit_reg <= 1'b0;
      compare_reg1_reg <= tmccs_pkg::CMP1_RESET;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      mode_reg <= mode_next;
      base_clock_override_reg <= base_clock_override_next;
      count_run_bit_reg <= count_run_bit_next;
      compare_reg1_reg <= compare_reg1_next;
    end
  end

  // ------------------------------------------------------------
  // source clock selection
  // ------------------------------------------------------------
  always_comb begin
    count_tick = 1'b0;
    if (base_clock_override_reg) begin
      count_tick = base_clock_tick;
    end else begin
      unique case (mode_reg.clk_sel)
        tmccs_pkg::TMCCS_CLK_PIN0: count_tick = pin0_rise;
        tmccs_pkg::TMCCS_CLK_DIV1: count_tick = 1'b1;
        tmccs_pkg::TMCCS_CLK_DIV4: count_tick = &presc_reg[1:0];
        tmccs_pkg::TMCCS_CLK_DIV16: count_tick = &presc_reg[3:0];
        tmccs_pkg::TMCCS_CLK_DIV32: count_tick = &presc_reg[4:0];
        tmccs_pkg::TMCCS_CLK_DIV64: count_tick = &presc_reg[5:0];
        tmccs_pkg::TMCCS_CLK_DIV128: count_tick = &presc_reg[6:0];
        tmccs_pkg::TMCCS_CLK_DIV256: count_tick = &presc_reg[7:0];
      endcase
    end
  end

  // ------------------------------------------------------------
  // prescaler and up-counter
  // ------------------------------------------------------------
  assign match_hit = count_tick && (count_reg == compare_reg1_reg);

  always_comb begin
    presc_next = presc_reg;
    count_next = count_reg;
    match1_next = match1_reg;
    if (clk_en) begin
      match1_next = count_run_bit_reg && match_hit;
      if (!count_run_bit_reg) begin
        presc_next = tmccs_pkg::PRESC_RESET;
        count_next = tmccs_pkg::COUNT_RESET;
      end else begin
        presc_next = presc_reg + 8'h01;
        if (match_hit && mode_reg.match1_clear_enable) begin
          count_next = tmccs_pkg::COUNT_RESET;
        end else if (count_tick) begin
          count_next = count_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      presc_reg <= tmccs_pkg::PRESC_RESET;
      count_reg <= tmccs_pkg::COUNT_RESET;
      match1_reg <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      count_reg <= count_next;
      match1_reg <= match1_next;
    end
  end

  assign match1_pulse = match1_reg;
  assign timer_count = count_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ------------------------------------------------------------
  // capture triggers
  // ------------------------------------------------------------
  always_comb begin
    load0 = soft_capture_strobe;
    load1 = 1'b0;
    unique case (mode_reg.capture_timing_sel)
      tmccs_pkg::TMCCS_CAP_OFF: begin
      end
      tmccs_pkg::TMCCS_CAP_PINS: begin
        load0 = load0 | pin0_rise;
        load1 = pin1_rise;
      end
      tmccs_pkg::TMCCS_CAP_PIN0: begin
        load0 = load0 | pin0_rise;
        load1 = pin0_fall;
      end
      tmccs_pkg::TMCCS_CAP_PARTNER: begin
        load0 = load0 | (PARTNER_OK & partner_rise);
        load1 = PARTNER_OK & partner_fall;
      end
    endcase
  end

  tmccs_capture_reg #(.WIDTH(COUNT_W)) u_cap0 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .load(load0),
    .value(count_reg),
    .held(capture_reg0)
  );

  tmccs_capture_reg #(.WIDTH(COUNT_W)) u_cap1 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .load(load1),
    .value(count_reg),
    .held(capture_reg1)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_run_tick;
    clk_en && count_run_bit_reg && count_tick;
  endsequence

  sequence s_run_idle;
    clk_en && count_run_bit_reg && !count_tick;
  endsequence

  soft_capture_a: assert property (clk_en && soft_capture_strobe |=> capture_reg0 == $past(count_reg))
    else $error("soft capture did not load capture 0");
  no_hw_capture_a: assert property (clk_en && mode_reg.capture_timing_sel == tmccs_pkg::TMCCS_CAP_OFF
    |=> $stable(capture_reg1))
    else $error("capture 1 loaded with capture disabled");
  pin1_capture_a: assert property (clk_en && mode_reg.capture_timing_sel == tmccs_pkg::TMCCS_CAP_PINS
    && pin1_rise |=> capture_reg1 == $past(count_reg))
    else $error("pin1 rise did not load capture 1");
  pin0_fall_a: assert property (clk_en && mode_reg.capture_timing_sel == tmccs_pkg::TMCCS_CAP_PIN0
    && pin0_fall |=> capture_reg1 == $past(count_reg))
    else $error("pin0 fall did not load capture 1");
  partner_rise_a: assert property (clk_en && PARTNER_OK
    && mode_reg.capture_timing_sel == tmccs_pkg::TMCCS_CAP_PARTNER
    && partner_rise |=> capture_reg0 == $past(count_reg))
    else $error("partner rise did not load capture 0");
  match_clear_a: assert property (s_run_tick ##0 (mode_reg.match1_clear_enable && match_hit)
    |=> count_reg == 16'h0000 && match1_pulse)
    else $error("counter not cleared on compare 1 match");
  no_clear_a: assert property (s_run_tick ##0 (!mode_reg.match1_clear_enable && match_hit)
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter cleared with clear disabled");
  override_idle_a: assert property (s_run_idle ##0 base_clock_override_reg |=> $stable(count_reg))
    else $error("counter moved without base tick");
  ext_clock_a: assert property (clk_en && count_run_bit_reg && !base_clock_override_reg
    && mode_reg.clk_sel == tmccs_pkg::TMCCS_CLK_PIN0 && !pin0_rise |=> $stable(count_reg))
    else $error("counter moved without pin0 rise");
  div4_rate_a: assert property (clk_en && count_run_bit_reg && !base_clock_override_reg
    && mode_reg.clk_sel == tmccs_pkg::TMCCS_CLK_DIV4 && presc_reg[1:0] != 2'b11 |=> $stable(count_reg))
    else $error("divide by 4 ticked early");
  stop_clear_a: assert property (clk_en && !count_run_bit_reg |=> count_reg == 16'h0000)
    else $error("stopped counter not cleared");

endmodule : tmccs_timer_mode

// ### tmccs_timer_mode_tb.sv
`timescale 1ns/10ps
module tmccs_timer_mode_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pin0 = 1'b0;
  logic pin1 = 1'b0;
  logic tick = 1'b0;
  logic ch7 = 1'b0;
  logic ch8 = 1'b0;
  logic ch9 = 1'b0;
  logic match1_pulse;
  logic [15:0] timer_count;
  int miscompares = 0;
  int n_checks = 0;
  int n_match = 0;
  int m0;
  int n;
  logic [31:0] r;
  logic [31:0] seed = 32'h8fc50695;
  logic [31:0] exp_q[$];
  int divs[7] = '{1, 4, 16, 32, 64, 128, 256};

  always #2 sys_clk = ~sys_clk;

  tmccs_timer_mode #(.CHANNEL(0), .COUNT_W(16)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_input_pin0(pin0), .timer_input_pin1(pin1), .base_clock_tick(tick),
    .channel7_match_out(ch7), .channel8_match_out(ch8), .channel9_match_out(ch9),
    .match1_pulse(match1_pulse), .timer_count(timer_count)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  function automatic logic [31:0] mode_word(input tmccs_pkg::tmccs_cap_sel_t cap, input logic cle,
                                            input logic [2:0] clk);
    return {24'h000000, 2'b01, cap, cle, clk};
  endfunction : mode_word

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // one classic cycle, held until ack is sampled high
  task automatic wb_cycle(input logic [7:0] adr, input logic we, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(adr, 1'b1, dat);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb_cycle(adr, 1'b0, 32'h00000000);
  endtask : rd

  task automatic ticks(input int cnt);
    repeat (cnt) begin
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask : ticks

  task automatic pin(input int which, input logic v);
    @(posedge sys_clk);
    case (which)
      0: pin0 <= v;
      1: pin1 <= v;
      7: ch7 <= v;
      8: ch8 <= v;
      default: ch9 <= v;
    endcase
    repeat (6) @(posedge sys_clk);
  endtask : pin

  // mode is changed only with the counter stopped
  task automatic setmode(input tmccs_pkg::tmccs_cap_sel_t cap, input logic cle, input logic [2:0] clk);
    wr(tmccs_pkg::OFF_RUN, 32'h00000000);
    wr(tmccs_pkg::OFF_MODE, mode_word(cap, cle, clk));
  endtask : setmode

  task automatic measure(input int div);
    logic [15:0] c;
    time t0;
    int k;
    k = 0;
    c = timer_count;
    do begin
      @(posedge sys_clk);
      k++;
    end while (timer_count === c && k < 600);
    c = timer_count;
    t0 = $time;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (timer_count === c && k < 600);
    check(32'(($time - t0) / 4), 32'(div));
  endtask : measure

  // ------------------------------------------------------------
  // read monitor and watchdog
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (match1_pulse === 1'b1) begin
      n_match++;
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        check(wb_dat_o, 32'hxxxxxxxx);
      end else begin
        check(wb_dat_o, exp_q.pop_front());
      end
    end
  end

  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(tmccs_pkg::OFF_MODE, 32'h00000040);
    rd(tmccs_pkg::OFF_CTRL, 32'h00000000);
    rd(tmccs_pkg::OFF_RUN, 32'h00000000);
    rd(tmccs_pkg::OFF_CAP0, 32'h00000000);
    rd(tmccs_pkg::OFF_COUNT, 32'h00000000);
    rd(8'h40, 32'h00000000);
    r = next_rand() & 32'h0000ffff;
    wr(tmccs_pkg::OFF_CMP1, r);
    rd(tmccs_pkg::OFF_CMP1, r);
    wr(tmccs_pkg::OFF_COUNT, 32'h00001234);
    rd(tmccs_pkg::OFF_COUNT, 32'h00000000);
    wr(tmccs_pkg::OFF_CTRL, 32'h00000010);
    setmode(tmccs_pkg::TMCCS_CAP_OFF, 1'b0, 3'h0);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    n = int'(next_rand() & 32'h00000007) + 3;
    ticks(n);
    rd(tmccs_pkg::OFF_COUNT, 32'(n));
    pin(0, 1'b1);
    pin(0, 1'b0);
    pin(7, 1'b1);
    pin(7, 1'b0);
    rd(tmccs_pkg::OFF_COUNT, 32'(n));
    rd(tmccs_pkg::OFF_CAP0, 32'h00000000);
    rd(tmccs_pkg::OFF_CAP1, 32'h00000000);
    wr(tmccs_pkg::OFF_MODE, mode_word(tmccs_pkg::TMCCS_CAP_OFF, 1'b0, 3'h0) & 32'hffffffbf);
    rd(tmccs_pkg::OFF_CAP0, 32'(n));
    ticks(2);
    wr(tmccs_pkg::OFF_MODE, mode_word(tmccs_pkg::TMCCS_CAP_OFF, 1'b0, 3'h0));
    rd(tmccs_pkg::OFF_CAP0, 32'(n));
    setmode(tmccs_pkg::TMCCS_CAP_PINS, 1'b0, 3'h0);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    ticks(4);
    pin(1, 1'b1);
    rd(tmccs_pkg::OFF_CAP1, 32'h00000004);
    ticks(2);
    pin(0, 1'b1);
    rd(tmccs_pkg::OFF_CAP0, 32'h00000006);
    pin(0, 1'b0);
    pin(1, 1'b0);
    rd(tmccs_pkg::OFF_CAP1, 32'h00000004);
    setmode(tmccs_pkg::TMCCS_CAP_PIN0, 1'b0, 3'h0);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    ticks(3);
    pin(0, 1'b1);
    rd(tmccs_pkg::OFF_CAP0, 32'h00000003);
    ticks(2);
    pin(0, 1'b0);
    pin(1, 1'b1);
    pin(1, 1'b0);
    rd(tmccs_pkg::OFF_CAP1, 32'h00000005);
    setmode(tmccs_pkg::TMCCS_CAP_PARTNER, 1'b0, 3'h0);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    ticks(2);
    pin(8, 1'b1);
    pin(9, 1'b1);
    rd(tmccs_pkg::OFF_CAP0, 32'h00000003);
    pin(7, 1'b1);
    rd(tmccs_pkg::OFF_CAP0, 32'h00000002);
    ticks(1);
    pin(7, 1'b0);
    rd(tmccs_pkg::OFF_CAP1, 32'h00000003);
    pin(8, 1'b0);
    pin(9, 1'b0);
    setmode(tmccs_pkg::TMCCS_CAP_OFF, 1'b1, 3'h0);
    wr(tmccs_pkg::OFF_CMP1, 32'h00000003);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    m0 = n_match;
    ticks(5);
    rd(tmccs_pkg::OFF_COUNT, 32'h00000001);
    check(32'(n_match - m0), 32'h00000001);
    setmode(tmccs_pkg::TMCCS_CAP_OFF, 1'b0, 3'h0);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    ticks(5);
    rd(tmccs_pkg::OFF_COUNT, 32'h00000005);
    wr(tmccs_pkg::OFF_RUN, 32'h00000000);
    rd(tmccs_pkg::OFF_COUNT, 32'h00000000);
    wr(tmccs_pkg::OFF_CTRL, 32'h00000000);
    setmode(tmccs_pkg::TMCCS_CAP_OFF, 1'b0, 3'h0);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    repeat (3) begin
      pin(0, 1'b1);
      pin(0, 1'b0);
    end
    ticks(2);
    rd(tmccs_pkg::OFF_COUNT, 32'h00000003);
    for (int i = 1; i < 8; i++) begin
      setmode(tmccs_pkg::TMCCS_CAP_OFF, 1'b0, 3'(i));
      wr(tmccs_pkg::OFF_RUN, 32'h00000001);
      measure(divs[i - 1]);
    end
    // clock enable low freezes a running counter
    setmode(tmccs_pkg::TMCCS_CAP_OFF, 1'b0, 3'h1);
    wr(tmccs_pkg::OFF_RUN, 32'h00000001);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    r = 32'(timer_count);
    repeat (8) @(posedge sys_clk);
    check(32'(timer_count), r);
    clk_en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    end_sim();
  end
endmodule : tmccs_timer_mode_tb
